// ==== hw/ubd_top.v ====
// Baud generator, plain divider timer and LIN break and autobaud logic.
`include "ubd_defines.vh"

module ubd_top #(
  parameter BRK_MIN_CYC = 16'h03E8,
  parameter MEAS_W = 16
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire lin_rx_i,
  input wire uart_txd_i,
  output reg lin_tx_o,
  output reg baud_tick_o,
  output reg divided_output_clock_o,
  output reg divider_irq_o
);

  // ---------------------------------------------------------------
  // State and register declarations
  // ---------------------------------------------------------------
  localparam S_PREP = 3'h0;
  localparam S_WAIT = 3'h1;
  localparam S_BRK = 3'h2;
  localparam S_SYNC = 3'h3;
  localparam S_MEAS = 3'h4;
  localparam S_ADJ = 3'h5;
  localparam S_FRAME = 3'h6;
  localparam [MEAS_W-1:0] MEAS_ONE = {{(MEAS_W-1){1'b0}}, 1'b1};

  reg [2:0] prescale_select_r;
  reg frac_en_r;
  reg src_t1_r;
  reg [7:0] baud_reload_r;
  reg [7:0] fraction_step_r;
  reg divider_enable_r;
  reg divider_mode_select_r;
  reg divider_overflow_flag_r;
  reg [7:0] div_cnt_r;
  reg [7:0] timer1_high_byte_r;
  reg baud_double_r;
  reg lin_master_r;
  reg auto_en_r;
  reg brk_go_r;
  reg [7:0] pre_cnt_r;
  reg [7:0] rel_cnt_r;
  reg [8:0] frac_acc_r;
  reg mcyc_r;
  reg [7:0] t1_cnt_r;
  reg t1_half_r;
  reg brk_busy_r;
  reg [3:0] brk_os_r;
  reg [4:0] brk_bits_r;
  reg rx_s1_r;
  reg rx_s2_r;
  reg rx_prev_r;
  reg [2:0] state_r;
  reg [MEAS_W-1:0] meas_cnt_r;
  reg [MEAS_W-1:0] meas_last_r;
  reg [2:0] falls_r;
  reg frame_seen_r;

  wire bus_req;
  wire wr_en;
  wire div_run;
  wire div_ovf;
  wire [7:0] pre_mask;
  wire [7:0] eff_reload;
  wire pre_tick;
  wire os_tick;
  wire [8:0] frac_sum;
  wire t1_ovf;
  wire t1_tick;
  wire gen_tick;
  wire rx_fall;
  wire rx_rise;
  wire [MEAS_W-1:0] meas_shift;
  wire [7:0] auto_reload;

  // Write one lane check: a byte lane must be enabled for the low byte.
  function lane_hit;
    input [7:0] adr;
    input [7:0] off;
    input [3:0] sel;
    begin
      lane_hit = (adr == off) && sel[0];
    end
  endfunction

  // ---------------------------------------------------------------
  // Bus qualification
  // ---------------------------------------------------------------
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_en = bus_req && wb_we_i;

  // ---------------------------------------------------------------
  // Baud chain: prescaler, reload timer and fraction
  // ---------------------------------------------------------------
  // Prescale mask selects a power of two divide.
  assign pre_mask = (8'h01 << prescale_select_r) - 8'h01;
  assign pre_tick = (pre_cnt_r == pre_mask);
  // A product of one would give clock/16; force a floor of two.
  assign eff_reload = ((prescale_select_r == `UBD_RST_PRE) && (baud_reload_r == `UBD_RST_BYTE))
                      ? 8'h01 : baud_reload_r;
  // A count left above a freshly lowered reload wraps at once instead of running to 255.
  assign os_tick = pre_tick && (rel_cnt_r >= eff_reload);
  assign frac_sum = {1'b0, frac_acc_r[7:0]} + {1'b0, fraction_step_r};

  // Timer 1 overflow; half rate unless the doubling bit is set.
  assign t1_ovf = mcyc_r && (t1_cnt_r == `UBD_CNT_MAX);
  assign t1_tick = t1_ovf && (baud_double_r || t1_half_r);

  // Select the oversample tick source; plain divider mode stops it unless Timer 1 is the source.
  assign gen_tick = src_t1_r ? t1_tick :
                    (divider_mode_select_r ? 1'b0 :
                    (frac_en_r ? (os_tick && frac_sum[8]) : os_tick));

  // Prescaler and reload counters run continuously.
  always @(posedge clk_i) begin
    if (rst_i) begin
      pre_cnt_r <= `UBD_RST_BYTE;
      rel_cnt_r <= `UBD_RST_BYTE;
      frac_acc_r <= 9'h000;
    end else begin
      pre_cnt_r <= pre_tick ? `UBD_RST_BYTE : pre_cnt_r + 8'h01;
      if (pre_tick) begin
        // Count restarts from zero at each wrap; the live reload is compared at every prescaler tick.
        rel_cnt_r <= (rel_cnt_r >= eff_reload) ? `UBD_RST_BYTE : rel_cnt_r + 8'h01;
      end
      if (os_tick && frac_en_r) begin
        frac_acc_r <= {1'b0, frac_sum[7:0]};
      end
    end
  end

  // Timer 1 counts machine cycles of two clocks with auto-reload.
  always @(posedge clk_i) begin
    if (rst_i) begin
      mcyc_r <= 1'b0;
      t1_cnt_r <= `UBD_RST_BYTE;
      t1_half_r <= 1'b0;
    end else begin
      mcyc_r <= !mcyc_r;
      if (t1_ovf) begin
        t1_cnt_r <= timer1_high_byte_r;
        t1_half_r <= !t1_half_r;
      end else if (mcyc_r) begin
        t1_cnt_r <= t1_cnt_r + 8'h01;
      end
    end
  end

  // Oversample tick output.
  always @(posedge clk_i) begin
    if (rst_i) begin
      baud_tick_o <= 1'b0;
    end else begin
      baud_tick_o <= gen_tick;
    end
  end

  // ---------------------------------------------------------------
  // Plain divider timer
  // ---------------------------------------------------------------
  assign div_run = divider_mode_select_r && divider_enable_r;
  assign div_ovf = div_run && (div_cnt_r == `UBD_CNT_MAX);

  // Counter, reload on overflow and the output pulses.
  always @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt_r <= `UBD_RST_BYTE;
      divided_output_clock_o <= 1'b0;
    end else begin
      if (div_ovf) begin
        div_cnt_r <= fraction_step_r;
      end else if (div_run) begin
        div_cnt_r <= div_cnt_r + 8'h01;
      end
      divided_output_clock_o <= div_ovf;
    end
  end

  // ---------------------------------------------------------------
  // Line input synchroniser and edge detect
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      rx_prev_r <= 1'b1;
    end else begin
      rx_s1_r <= lin_rx_i;
      rx_s2_r <= rx_s1_r;
      rx_prev_r <= rx_s2_r;
    end
  end

  assign rx_fall = rx_prev_r && !rx_s2_r;
  assign rx_rise = !rx_prev_r && rx_s2_r;

  // ---------------------------------------------------------------
  // Break generator for master nodes
  // ---------------------------------------------------------------
  // Break is held low for a counted number of bit times.
  always @(posedge clk_i) begin
    if (rst_i) begin
      brk_busy_r <= 1'b0;
      brk_os_r <= 4'h0;
      brk_bits_r <= 5'h00;
      lin_tx_o <= 1'b1;
    end else begin
      if (!brk_busy_r) begin
        if (brk_go_r && lin_master_r) begin
          brk_busy_r <= 1'b1;
          brk_os_r <= 4'h0;
          brk_bits_r <= 5'h00;
        end
      end else if (gen_tick) begin
        brk_os_r <= brk_os_r + 4'h1;
        if (brk_os_r == `UBD_OS_LAST) begin
          brk_bits_r <= brk_bits_r + 5'h01;
          if (brk_bits_r == `UBD_BREAK_BITS - 5'h01) begin
            brk_busy_r <= 1'b0;
          end
        end
      end
      // Sync byte and identifier come from the serial core.
      lin_tx_o <= brk_busy_r ? 1'b0 : uart_txd_i;
    end
  end

  // ---------------------------------------------------------------
  // Autobaud measuring timer and sequence
  // ---------------------------------------------------------------
  // Eight bit times span five falls of the sync byte.
  assign meas_shift = meas_last_r >> (`UBD_MEAS_SHIFT + {1'b0, prescale_select_r});
  assign auto_reload = (meas_shift[7:0] == `UBD_RST_BYTE) ? `UBD_RST_BYTE
                       : meas_shift[7:0] - 8'h01;

  // Sequence: prepare, wait for break, time sync, adjust, frame.
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= S_PREP;
      meas_cnt_r <= {MEAS_W{1'b0}};
      meas_last_r <= {MEAS_W{1'b0}};
      falls_r <= 3'h0;
      frame_seen_r <= 1'b0;
    end else begin
      case (state_r)
        S_PREP: begin
          meas_cnt_r <= {MEAS_W{1'b0}};
          falls_r <= 3'h0;
          if (auto_en_r) begin
            state_r <= S_WAIT;
          end
        end
        S_WAIT: begin
          meas_cnt_r <= {MEAS_W{1'b0}};
          if (!auto_en_r) begin
            state_r <= S_PREP;
          end else if (rx_fall) begin
            state_r <= S_BRK;
          end
        end
        S_BRK: begin
          if (meas_cnt_r != {MEAS_W{1'b1}}) begin
            meas_cnt_r <= meas_cnt_r + MEAS_ONE;
          end
          if (rx_rise) begin
            state_r <= (meas_cnt_r >= BRK_MIN_CYC[MEAS_W-1:0]) ? S_SYNC : S_WAIT;
          end
        end
        S_SYNC: begin
          meas_cnt_r <= {MEAS_W{1'b0}};
          falls_r <= 3'h0;
          if (rx_fall) begin
            state_r <= S_MEAS;
          end
        end
        S_MEAS: begin
          meas_cnt_r <= meas_cnt_r + MEAS_ONE;
          if (rx_fall) begin
            falls_r <= falls_r + 3'h1;
            if (falls_r == `UBD_SYNC_FALLS - 3'h1) begin
              meas_last_r <= meas_cnt_r + MEAS_ONE;
              state_r <= S_ADJ;
            end
          end
        end
        S_ADJ: begin
          state_r <= S_FRAME;
        end
        S_FRAME: begin
          frame_seen_r <= 1'b1;
          state_r <= S_PREP;
        end
        default: begin
          state_r <= S_PREP;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  // Software writes; autobaud updates the reload in its adjust step.
  always @(posedge clk_i) begin
    if (rst_i) begin
      prescale_select_r <= `UBD_RST_PRE;
      frac_en_r <= 1'b0;
      src_t1_r <= 1'b0;
      baud_reload_r <= `UBD_RST_BYTE;
      fraction_step_r <= `UBD_RST_BYTE;
      divider_enable_r <= 1'b0;
      divider_mode_select_r <= 1'b0;
      timer1_high_byte_r <= `UBD_RST_BYTE;
      baud_double_r <= 1'b0;
      lin_master_r <= 1'b0;
      auto_en_r <= 1'b0;
      brk_go_r <= 1'b0;
    end else begin
      brk_go_r <= 1'b0;
      if (wr_en && lane_hit(wb_adr_i, `UBD_ADR_BAUD_CTRL, wb_sel_i)) begin
        prescale_select_r <= wb_dat_i[`UBD_BC_PRE_LSB +: 3];
        frac_en_r <= wb_dat_i[`UBD_BC_FRAC_EN];
        src_t1_r <= wb_dat_i[`UBD_BC_SRC_T1];
      end
      if (state_r == S_ADJ) begin
        baud_reload_r <= auto_reload;
      end else if (wr_en && lane_hit(wb_adr_i, `UBD_ADR_BAUD_RELOAD, wb_sel_i)) begin
        baud_reload_r <= wb_dat_i[7:0];
      end
      if (wr_en && lane_hit(wb_adr_i, `UBD_ADR_FRAC_STEP, wb_sel_i)) begin
        fraction_step_r <= wb_dat_i[7:0];
      end
      if (wr_en && lane_hit(wb_adr_i, `UBD_ADR_DIV_CTRL, wb_sel_i)) begin
        divider_enable_r <= wb_dat_i[`UBD_DC_EN];
        divider_mode_select_r <= wb_dat_i[`UBD_DC_MODE];
      end
      if (wr_en && lane_hit(wb_adr_i, `UBD_ADR_TIMER1, wb_sel_i)) begin
        timer1_high_byte_r <= wb_dat_i[7:0];
      end
      if (wr_en && (wb_adr_i == `UBD_ADR_TIMER1) && wb_sel_i[1]) begin
        baud_double_r <= wb_dat_i[`UBD_T1_DOUBLE];
      end
      if (wr_en && lane_hit(wb_adr_i, `UBD_ADR_LIN_CTRL, wb_sel_i)) begin
        lin_master_r <= wb_dat_i[`UBD_LC_MASTER];
        brk_go_r <= wb_dat_i[`UBD_LC_BREAK];
        auto_en_r <= wb_dat_i[`UBD_LC_AUTO];
      end
    end
  end

  // Overflow flag: hardware set wins over a write-one clear.
  always @(posedge clk_i) begin
    if (rst_i) begin
      divider_overflow_flag_r <= 1'b0;
      divider_irq_o <= 1'b0;
    end else begin
      if (div_ovf) begin
        divider_overflow_flag_r <= 1'b1;
      end else if (wr_en && lane_hit(wb_adr_i, `UBD_ADR_DIV_CTRL, wb_sel_i)
                   && wb_dat_i[`UBD_DC_OVF]) begin
        divider_overflow_flag_r <= 1'b0;
      end
      divider_irq_o <= div_ovf;
    end
  end

  // ---------------------------------------------------------------
  // Bus answer and read data
  // ---------------------------------------------------------------
  // Ack one cycle after the request; unmapped reads return zero.
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= 32'h00000000;
      if (bus_req && !wb_we_i) begin
        if (wb_adr_i == `UBD_ADR_BAUD_CTRL) begin
          wb_dat_o <= {27'h0000000, src_t1_r, frac_en_r, prescale_select_r};
        end else if (wb_adr_i == `UBD_ADR_BAUD_RELOAD) begin
          wb_dat_o <= {24'h000000, baud_reload_r};
        end else if (wb_adr_i == `UBD_ADR_FRAC_STEP) begin
          wb_dat_o <= {24'h000000, fraction_step_r};
        end else if (wb_adr_i == `UBD_ADR_DIV_CTRL) begin
          wb_dat_o <= {29'h00000000, divider_overflow_flag_r, divider_mode_select_r,
                       divider_enable_r};
        end else if (wb_adr_i == `UBD_ADR_DIV_RESULT) begin
          wb_dat_o <= {24'h000000, div_cnt_r};
        end else if (wb_adr_i == `UBD_ADR_TIMER1) begin
          wb_dat_o <= {23'h000000, baud_double_r, timer1_high_byte_r};
        end else if (wb_adr_i == `UBD_ADR_LIN_CTRL) begin
          wb_dat_o <= {28'h0000000, brk_busy_r, auto_en_r, 1'b0, lin_master_r};
        end else if (wb_adr_i == `UBD_ADR_LIN_STAT) begin
          wb_dat_o <= {meas_last_r, 12'h000, frame_seen_r, state_r};
        end
      end
    end
  end

endmodule // ubd_top

// ==== include/ubd_defines.vh ====
// Constants for the baud divider and LIN synchronisation block.
// Function
// - Without fraction, baud is clock over 16 times 2^prescale times reload plus one.
// - With fraction enabled, prescaled rate is scaled by step over 256.
// - Generated baud never exceeds one thirty-second of the clock.
// - Eight-bit baud reload is software writable and reloaded into the timer.
// - Prescale select divides by a power of two: 1, 2, 4 and onward.
// - Timer 1 source gives 2^double times clock over 64 times (256 minus high byte).
// - Divider mode select set turns the divider into a plain timer, no baud unless Timer 1 is the source.
// - Plain timer counts up each clock from the step value, readable as result.
// - Each plain timer overflow sets the overflow flag and raises a request.
// - Plain timer output rate is clock over 256 minus step.
// - A break holds the line dominant for at least 13 bit times.
// - Header is break, sync byte 55h, identifier; data and checksum follow.
// - Only a master node sends the header.
// - Break is made by separate logic; sync and identifier are normal characters.
// - The incoming rate is measured by the Timer 2 counter and sets baud timing; here the separate autobaud counter meas_cnt_r does the measuring.
// - Every received header is measured again and the baud reprogrammed.
// - Sequence: prepare, wait for frame, adjust baud, then handle the frame.
// - Standard LIN uses the prescaler alone for automatic baud calculation; here autobaud writes the reload register and keeps the software prescale.
`ifndef UBD_DEFINES_VH
`define UBD_DEFINES_VH

// Register byte offsets.
`define UBD_ADR_BAUD_CTRL 8'h00
`define UBD_ADR_BAUD_RELOAD 8'h04
`define UBD_ADR_FRAC_STEP 8'h08
`define UBD_ADR_DIV_CTRL 8'h0C
`define UBD_ADR_DIV_RESULT 8'h10
`define UBD_ADR_TIMER1 8'h14
`define UBD_ADR_LIN_CTRL 8'h18
`define UBD_ADR_LIN_STAT 8'h1C

// Baud control fields.
`define UBD_BC_PRE_LSB 0
`define UBD_BC_FRAC_EN 3
`define UBD_BC_SRC_T1 4
// Divider control fields.
`define UBD_DC_EN 0
`define UBD_DC_MODE 1
`define UBD_DC_OVF 2
// Timer 1 fields.
`define UBD_T1_DOUBLE 8
// LIN control fields.
`define UBD_LC_MASTER 0
`define UBD_LC_BREAK 1
`define UBD_LC_AUTO 2

// Reset values.
`define UBD_RST_BYTE 8'h00
`define UBD_RST_PRE 3'h0

// Fixed figures of the divider chain.
`define UBD_CNT_MAX 8'hFF
`define UBD_OS_LAST 4'hF
`define UBD_SYNC_FALLS 3'h4
`define UBD_MEAS_SHIFT 4'h7
`define UBD_BREAK_BITS 5'hD

`endif

// ==== sim/ubd_lin_node.sv ====
// LIN master node model that sends break, sync byte and identifier.
module ubd_lin_node (
  input wire clk_i,
  output logic lin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // The line rests recessive high between headers.
  initial lin_o = 1'b1;
  // Holds the line at one level for a number of clocks.
  task automatic hold(input logic v, input int n);
    lin_o <= v;
    repeat (n) @(posedge clk_i);
  endtask
  // Sends start bit, eight data bits low bit first, and stop bit.
  task automatic send_char(input logic [7:0] c, input int b);
    hold(1'b0, b);
    for (int i = 0; i < 8; i++) hold(c[i], b);
    hold(1'b1, b);
  endtask
  // Sends break, delimiter, sync byte and identifier.
  task automatic send_header(input int b, input logic [7:0] id);
    @(posedge clk_i);
    hold(1'b0, 13 * b);
    hold(1'b1, b);
    send_char(8'h55, b);
    send_char(id, b);
  endtask
endmodule // ubd_lin_node

// ==== sim/ubd_top_sva.sv ====
// Port checker for the baud divider and LIN block.
`include "ubd_defines.vh"
module ubd_top_sva (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire lin_rx_i,
  input wire uart_txd_i,
  input wire lin_tx_o,
  input wire baud_tick_o,
  input wire divided_output_clock_o,
  input wire divider_irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [8:0] lo_ticks_r;
  wire lin_wr;
  // Write of the LIN control register seen at its acknowledge.
  assign lin_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0]
    && (wb_adr_i == `UBD_ADR_LIN_CTRL);
  // Counts oversample ticks while the line is held low.
  always @(posedge clk_i) begin
    if (rst_i || lin_tx_o) begin
      lo_ticks_r <= 9'h000;
    end else if (baud_tick_o) begin
      lo_ticks_r <= lo_ticks_r + 9'h001;
    end
  end
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > `UBD_ADR_LIN_STAT
    |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  a_tick_max_rate: assert property (baud_tick_o |=> !baud_tick_o)
    else $error("ticks faster than half the clock");
  a_irq_with_ovf: assert property (divider_irq_o == divided_output_clock_o)
    else $error("irq and overflow pulse differ");
  a_break_start: assert property (lin_wr && wb_dat_i[1:0] == 2'h3 |-> ##[1:3] !lin_tx_o)
    else $error("master break did not start");
  a_slave_quiet: assert property ((lin_wr && !wb_dat_i[0] && lin_tx_o && uart_txd_i)
    ##1 uart_txd_i [*3] |=> lin_tx_o) else $error("slave drove a break");
  a_break_len: assert property ($rose(lin_tx_o) && lo_ticks_r > 9'h010
    |-> lo_ticks_r >= 9'd207) else $error("break shorter than 13 bits");
  a_tx_follow: assert property (lin_tx_o |-> $past(uart_txd_i))
    else $error("line high while serial data low");
  a_reset_quiet: assert property (@(posedge clk_i) disable iff (1'b0)
    rst_i |=> !wb_ack_o && lin_tx_o && !baud_tick_o && !divider_irq_o)
    else $error("outputs active in reset");
endmodule // ubd_top_sva

// ==== sim/ubd_top_tb_top.sv ====
// Self-checking bench for the baud divider and LIN block.
`include "ubd_defines.vh"
module ubd_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic uart_txd_i = 1'b1;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, lin_rx_i, lin_tx_o, baud_tick_o, divided_output_clock_o, divider_irq_o;
  int err_total = 0;
  int n_checks = 0;
  int cyc_cnt = 0;
  int n;
  int m;
  logic [31:0] rd;
  // Long-break minimum kept above one bit time of the test headers.
  ubd_top #(.BRK_MIN_CYC(16'h00C8), .MEAS_W(16)) u_ubd_top (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .lin_rx_i(lin_rx_i), .uart_txd_i(uart_txd_i), .lin_tx_o(lin_tx_o),
    .baud_tick_o(baud_tick_o), .divided_output_clock_o(divided_output_clock_o),
    .divider_irq_o(divider_irq_o));
  ubd_lin_node u_ubd_lin_node (.clk_i(clk_i), .lin_o(lin_rx_i));
  // 25 MHz clock.
  initial forever #20 clk_i = ~clk_i;
  // Compares a value and counts the outcome.
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", s, e, g);
    end
  endtask
  // One classic Wishbone cycle; read data lands in rd.
  task automatic wb_go(input logic we, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    t = 0;
    do begin
      @(posedge clk_i);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (t >= 20) chk("wb_ack", 32'h1, 32'h0);
  endtask
  // Clocks from one pulse to the next, second gap after a change.
  task automatic gap_chk(input logic s, input int e);
    int g;
    for (int k = 0; k < 3; k++) begin
      g = 0;
      do begin
        @(posedge clk_i);
        g++;
      end while ((s ? divided_output_clock_o : baud_tick_o) !== 1'b1 && g < 600);
    end
    if (s)
      chk("ovf_gap", e, g);
    else
      chk("tick_gap", e, g);
  endtask
  // Counts ticks and divider requests over a number of clocks.
  task automatic tick_cnt(input int c);
    n = 0;
    m = 0;
    repeat (c) begin
      @(posedge clk_i);
      if (baud_tick_o === 1'b1) n++;
      if (divider_irq_o === 1'b1) m++;
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Cuts a hang short.
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 40000) begin
      err_total++;
      print_verdict();
    end
  end
  // Main sequence.
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      wb_go(1'b0, 8'(i * 4), 32'h0);
      chk("reset_value", 32'h0, rd);
    end
    wb_go(1'b1, 8'h40, 32'hFF);
    wb_go(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, rd);
    wb_go(1'b0, `UBD_ADR_BAUD_RELOAD, 32'h0);
    chk("reload_kept", 32'h0, rd);
    for (int p = 0; p < 3; p++) begin
      wb_go(1'b1, `UBD_ADR_BAUD_CTRL, p);
      wb_go(1'b1, `UBD_ADR_BAUD_RELOAD, 32'h2);
      wb_go(1'b0, `UBD_ADR_BAUD_RELOAD, 32'h0);
      chk("baud_reload", 32'h2, rd);
      gap_chk(1'b0, 3 << p);
    end
    wb_go(1'b1, `UBD_ADR_BAUD_CTRL, 32'h0);
    wb_go(1'b1, `UBD_ADR_BAUD_RELOAD, 32'h0);
    gap_chk(1'b0, 2);
    wb_go(1'b1, `UBD_ADR_BAUD_RELOAD, 32'h1);
    wb_go(1'b1, `UBD_ADR_FRAC_STEP, 32'h80);
    wb_go(1'b1, `UBD_ADR_BAUD_CTRL, 32'h8);
    tick_cnt(256);
    chk("frac_ticks", 32'h1, 32'(n >= 63 && n <= 65));
    wb_go(1'b1, `UBD_ADR_BAUD_CTRL, 32'h10);
    wb_go(1'b1, `UBD_ADR_TIMER1, 32'h1FC);
    gap_chk(1'b0, 8);
    wb_go(1'b1, `UBD_ADR_TIMER1, 32'h0FC);
    gap_chk(1'b0, 16);
    wb_go(1'b1, `UBD_ADR_BAUD_CTRL, 32'h0);
    wb_go(1'b1, `UBD_ADR_FRAC_STEP, 32'hFC);
    wb_go(1'b1, `UBD_ADR_DIV_CTRL, 32'h3);
    gap_chk(1'b1, 4);
    tick_cnt(40);
    chk("div_mode_ticks", 32'h0, n);
    chk("irq_pulses", 32'hA, m);
    wb_go(1'b0, `UBD_ADR_DIV_RESULT, 32'h0);
    chk("result_range", 32'h1, 32'(rd[7:0] >= 8'hFC && rd[31:8] == 24'h0));
    wb_go(1'b0, `UBD_ADR_DIV_CTRL, 32'h0);
    chk("ovf_flag", 32'h1, rd[2]);
    wb_go(1'b1, `UBD_ADR_DIV_CTRL, 32'h0);
    wb_go(1'b1, `UBD_ADR_DIV_CTRL, 32'h4);
    wb_go(1'b0, `UBD_ADR_DIV_CTRL, 32'h0);
    chk("ovf_clear", 32'h0, rd[2:0]);
    wb_go(1'b1, `UBD_ADR_LIN_CTRL, 32'h3);
    n = 0;
    for (int t = 0; t < 2000 && (n == 0 || lin_tx_o === 1'b0); t++) begin
      @(posedge clk_i);
      if (lin_tx_o === 1'b0 && baud_tick_o === 1'b1) n++;
    end
    chk("break_ticks", 32'h1, 32'(n >= 207 && n <= 209));
    wb_go(1'b1, `UBD_ADR_LIN_CTRL, 32'h2);
    n = 0;
    repeat (20) begin
      @(posedge clk_i);
      if (lin_tx_o !== 1'b1) n++;
    end
    chk("slave_break", 32'h0, n);
    @(posedge clk_i);
    uart_txd_i <= 1'b0;
    @(posedge clk_i);
    uart_txd_i <= 1'b1;
    @(posedge clk_i);
    chk("tx_pass", 32'h0, lin_tx_o);
    wb_go(1'b1, `UBD_ADR_LIN_CTRL, 32'h4);
    u_ubd_lin_node.send_header(64, 8'hD5);
    wb_go(1'b0, `UBD_ADR_BAUD_RELOAD, 32'h0);
    chk("auto_reload", 32'h3, rd);
    wb_go(1'b0, `UBD_ADR_LIN_STAT, 32'h0);
    chk("frame_seen", 32'h1, rd[3]);
    u_ubd_lin_node.send_header(96, 8'hD5);
    wb_go(1'b0, `UBD_ADR_BAUD_RELOAD, 32'h0);
    chk("auto_reload2", 32'h5, rd);
    gap_chk(1'b0, 6);
    print_verdict();
  end
endmodule // ubd_top_tb_top
bind ubd_top ubd_top_sva u_ubd_top_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .lin_rx_i(lin_rx_i),
  .uart_txd_i(uart_txd_i), .lin_tx_o(lin_tx_o), .baud_tick_o(baud_tick_o),
  .divided_output_clock_o(divided_output_clock_o), .divider_irq_o(divider_irq_o));
